// [core/ycb_regs.sv]
/*
 * Y circular buffer bounds register bank with APB slave and a
 * pointer that steps through the buffer.
 * Assumes single pclk domain, asynchronous active-low presetn.
 */
`timescale 1ns/1ps
module ycb_regs
    import ycb_pkg::*;
#(
    parameter int ADDR_W = ycb_pkg::YCB_AW
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [ycb_pkg::YCB_DW-1:0] pwdata,
    output logic [ycb_pkg::YCB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [ycb_pkg::YCB_RW-1:0] y_start_addr,
    output logic [ycb_pkg::YCB_RW-1:0] y_end_addr,
    output logic [ycb_pkg::YCB_RW-1:0] y_ptr
);
    import ycb_pkg::*;

    // Decoder needs the full register offset field
    if (ADDR_W < YCB_AW) begin : g_addr_chk
        $error("ADDR_W too small");
    end

    // ************************************************************
    // State
    // ************************************************************
    logic [14:0] start_q, start_d;
    logic [14:0] end_q, end_d;
    logic en_q, en_d;
    logic [15:0] ptr_q, ptr_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;
    logic [15:0] start_full, end_full, stepped;
    logic setup, wr, hit;
    logic [11:0] off;

    assign start_full = {start_q, YCB_START_LSB};
    assign end_full = {end_q, YCB_END_LSB};
    assign off = paddr[11:0];
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && ready_q;
    assign hit = (off == YCB_START_OFF) || (off == YCB_END_OFF)
        || (off == YCB_CTRL_OFF) || (off == YCB_ADDR_OFF);

    ycb_wrap #(.AW(YCB_RW)) u_wrap (
        .ptr(ptr_q),
        .step(YCB_WORD_STEP),
        .start_addr(start_full),
        .end_addr(end_full),
        .mod_en(en_q),
        .next_ptr(stepped)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        start_d = start_q;
        end_d = end_q;
        en_d = en_q;
        ptr_d = ptr_q;
        rdata_d = rdata_q;
        ready_d = setup;
        err_d = setup && !hit;
        if (wr && !err_q) begin
            case (off)
                YCB_START_OFF: begin
                    start_d = pwdata[15:1];
                end
                YCB_END_OFF: begin
                    end_d = pwdata[15:1];
                end
                YCB_CTRL_OFF: begin
                    en_d = pwdata[YCB_CTRL_EN_BIT];
                    if (pwdata[YCB_CTRL_UPD_BIT]) begin
                        ptr_d = stepped;
                    end
                end
                YCB_ADDR_OFF: begin
                    ptr_d = pwdata[15:0];
                end
                default: begin
                end
            endcase
        end
        if (setup && !pwrite) begin
            case (off)
                YCB_START_OFF: rdata_d = {16'h0000, start_full};
                YCB_END_OFF: rdata_d = {16'h0000, end_full};
                YCB_CTRL_OFF: rdata_d = {31'h00000000, en_q};
                YCB_ADDR_OFF: rdata_d = {16'h0000, ptr_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= YCB_START_RST[15:1];
            end_q <= YCB_END_RST[15:1];
            en_q <= 1'b0;
            ptr_q <= 16'h0000;
            rdata_q <= 32'h00000000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            start_q <= start_d;
            end_q <= end_d;
            en_q <= en_d;
            ptr_q <= ptr_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    logic [15:0] ys_q, ye_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ys_q <= YCB_START_RST;
            ye_q <= YCB_END_RST;
        end else begin
            ys_q <= {start_d, YCB_START_LSB};
            ye_q <= {end_d, YCB_END_LSB};
        end
    end
    assign y_start_addr = ys_q;
    assign y_end_addr = ye_q;
    assign y_ptr = ptr_q;
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    start_even_a: assert property (@(posedge pclk) disable iff (!presetn)
        y_start_addr[0] == 1'b0) else $error("start bit 0 not zero");
    end_odd_a: assert property (@(posedge pclk) disable iff (!presetn)
        y_end_addr[0] == 1'b1) else $error("end bit 0 not one");
    start_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !err_q && off == YCB_START_OFF) |=> y_start_addr[15:1] == $past(pwdata[15:1]))
        else $error("start write lost");
    end_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !err_q && off == YCB_END_OFF) |=> y_end_addr[15:1] == $past(pwdata[15:1]))
        else $error("end write lost");
    start_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && off == YCB_START_OFF) |=> (prdata[0] == 1'b0 && pready))
        else $error("start read wrong");
    end_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && off == YCB_END_OFF) |=> (prdata[0] == 1'b1 && pready))
        else $error("end read wrong");
    wrap_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !err_q && off == YCB_CTRL_OFF && pwdata[YCB_CTRL_UPD_BIT] && en_q
        && ptr_q + YCB_WORD_STEP > end_full) |=> y_ptr == $past(start_full))
        else $error("pointer did not wrap");
    ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready) else $error("pready not one cycle");
    start_wr_c: cover property (@(posedge pclk) disable iff (!presetn)
        wr && off == YCB_START_OFF);
    end_wr_c: cover property (@(posedge pclk) disable iff (!presetn)
        wr && off == YCB_END_OFF);
    wrap_c: cover property (@(posedge pclk) disable iff (!presetn)
        en_q && wr && off == YCB_CTRL_OFF && stepped == start_full);
endmodule

// [core/ycb_pkg.sv]
/*
 * Package for the Y circular buffer bounds register bank.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package ycb_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] YCB_START_OFF = 12'h000;
    localparam logic [11:0] YCB_END_OFF = 12'h004;
    localparam logic [11:0] YCB_CTRL_OFF = 12'h008;
    localparam logic [11:0] YCB_ADDR_OFF = 12'h00c;
    localparam int YCB_AW = 12;
    localparam int YCB_DW = 32;
    localparam int YCB_RW = 16;
    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam logic [15:0] YCB_START_RST = 16'h0000;
    localparam logic [15:0] YCB_END_RST = 16'h0001;
    localparam logic YCB_START_LSB = 1'h0;
    localparam logic YCB_END_LSB = 1'h1;
    localparam int YCB_CTRL_EN_BIT = 0;
    localparam int YCB_CTRL_UPD_BIT = 1;
    localparam logic [15:0] YCB_WORD_STEP = 16'h0002;
endpackage

// [core/ycb_wrap.sv]
/*
 * Modulo pointer step for the Y address generator.
 * Assumes bounds as held by the register bank (start even, end odd).
 */
`timescale 1ns/1ps
module ycb_wrap #(
    parameter int AW = 16
) (
    input wire logic [AW-1:0] ptr,
    input wire logic [AW-1:0] step,
    input wire logic [AW-1:0] start_addr,
    input wire logic [AW-1:0] end_addr,
    input wire logic mod_en,
    output logic [AW-1:0] next_ptr
);
    logic [AW-1:0] sum;
    always_comb begin
        sum = ptr + step;
        // Word pointer passing the odd end byte returns to start
        if (mod_en && (sum > end_addr)) begin
            next_ptr = start_addr;
        end else begin
            next_ptr = sum;
        end
    end
endmodule

// [test/ycb_regs_tb.sv]
/*
 * Self-checking bench for the Y circular buffer bounds register bank.
 * Assumes ycb_pkg and ycb_regs compiled first; APB answer after setup.
 */
`timescale 1ns/1ps
module ycb_regs_tb;
    import ycb_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ycb_row_s;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, er;
    logic [15:0] y_start_addr, y_end_addr, y_ptr;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    ycb_row_s rows[4] = '{'{YCB_START_OFF, 32'hdeadffff, 32'h0000fffe},
        '{YCB_START_OFF, 32'h00001235, 32'h00001234},
        '{YCB_END_OFF, 32'h0000abcc, 32'h0000abcd},
        '{YCB_END_OFF, 32'hffff0000, 32'h00000001}};
    ycb_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .y_start_addr(y_start_addr), .y_end_addr(y_end_addr), .y_ptr(y_ptr));
    // ************************************************************
    // Clock, timeout and shared tasks
    // ************************************************************
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    task automatic reset_vals();
        chk(y_start_addr, 32'h0);
        chk(y_end_addr, 32'h1);
        chk(y_ptr, 32'h0);
        xfer(1'b0, YCB_START_OFF, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, YCB_END_OFF, 32'h0);
        chk(rd, 32'h1);
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        do_reset();
        reset_vals();
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].d);
            chk({31'h0, er}, 32'h0);
            xfer(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].e);
            chk(rows[i].a == YCB_START_OFF ? y_start_addr : y_end_addr, rows[i].e);
        end
        // Unmapped write is refused and leaves the end bound alone
        xfer(1'b1, 12'h010, 32'h00005555);
        chk({31'h0, er}, 32'h1);
        xfer(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        chk(y_end_addr, 32'h1);
        // Pointer steps then wraps past the end bound
        xfer(1'b1, YCB_START_OFF, 32'h00001000);
        xfer(1'b1, YCB_END_OFF, 32'h00001004);
        xfer(1'b1, YCB_ADDR_OFF, 32'h00001002);
        xfer(1'b1, YCB_CTRL_OFF, 32'h00000003);
        chk(y_ptr, 32'h1004);
        xfer(1'b1, YCB_CTRL_OFF, 32'h00000003);
        chk(y_ptr, 32'h1000);
        // Inside the bounds the pointer steps on
        xfer(1'b1, YCB_CTRL_OFF, 32'h00000003);
        chk(y_ptr, 32'h1002);
        xfer(1'b0, YCB_CTRL_OFF, 32'h0);
        chk(rd, 32'h1);
        xfer(1'b0, YCB_ADDR_OFF, 32'h0);
        chk(rd, 32'h1002);
        // Enable cleared: the pointer runs past the end bound
        xfer(1'b1, YCB_CTRL_OFF, 32'h00000002);
        chk(y_ptr, 32'h1004);
        xfer(1'b1, YCB_CTRL_OFF, 32'h00000002);
        chk(y_ptr, 32'h1006);
        xfer(1'b0, YCB_CTRL_OFF, 32'h0);
        chk(rd, 32'h0);
        // Second reset in mid-run restores the bounds
        do_reset();
        reset_vals();
        close_out();
    end
endmodule
